// ==== src/mlm_pkg.sv ====
// Address map, port enumeration and slot constants of the multilayer matrix.
package mlm_pkg;

   // ----------------------------------------------------------------------
   // Slave ports of the matrix
   // ----------------------------------------------------------------------
   localparam int NUM_PORTS = 9;

   typedef enum logic [3:0]
   {
      PORT_CODE,
      PORT_LSRAM,
      PORT_SRAM0,
      PORT_SRAM1,
      PORT_APB0,
      PORT_APB1,
      PORT_BITBAND,
      PORT_AHBP,
      PORT_PPB
   } mlm_port_type;

   // ----------------------------------------------------------------------
   // Address windows (base inclusive, end exclusive)
   // ----------------------------------------------------------------------
   localparam logic [31:0] VECT_END   = 32'h0000_0400;
   localparam logic [31:0] FLASH_END  = 32'h0008_0000;
   localparam logic [31:0] LSRAM_BASE = 32'h1000_0000;
   localparam logic [31:0] LSRAM_END  = 32'h1000_8000;
   localparam logic [31:0] ROM_BASE   = 32'h1FFF_0000;
   localparam logic [31:0] ROM_END    = 32'h1FFF_2000;
   localparam logic [31:0] SRAM0_BASE = 32'h2007_C000;
   localparam logic [31:0] SRAM1_BASE = 32'h2008_0000;
   localparam logic [31:0] SRAM1_END  = 32'h2008_4000;
   localparam logic [31:0] APB0_BASE  = 32'h4000_0000;
   localparam logic [31:0] APB1_BASE  = 32'h4008_0000;
   localparam logic [31:0] APB_END    = 32'h4010_0000;
   localparam logic [31:0] BB_BASE    = 32'h4200_0000;
   localparam logic [31:0] BB_END     = 32'h4400_0000;
   localparam logic [31:0] AHBP_BASE  = 32'h5000_0000;
   localparam logic [31:0] AHBP_END   = 32'h5020_0000;
   localparam logic [31:0] PPB_BASE   = 32'hE000_0000;
   localparam logic [31:0] PPB_END    = 32'hE010_0000;

   // ----------------------------------------------------------------------
   // Peripheral slots
   // ----------------------------------------------------------------------
   localparam int SLOT_LSB = 14;
   localparam int SLOT_W   = 7;

   localparam logic [4:0] SLOT_TWO_WIRE2 = 5'h08;
   localparam logic [4:0] SLOT_AUDIO     = 5'h0A;
   localparam logic [4:0] SLOT_RIT       = 5'h0C;
   localparam logic [4:0] SLOT_MC_PWM    = 5'h0E;
   localparam logic [4:0] SLOT_QUAD_DEC  = 5'h0F;
   localparam logic [4:0] SLOT_SYSCON    = 5'h1F;

   // Slots 2 to 7 of the second APB region are populated as well.
   localparam logic [31:0] APB1_USED = 32'h0000_00FC
                                     | (32'h0000_0001 << SLOT_TWO_WIRE2)
                                     | (32'h0000_0001 << SLOT_AUDIO)
                                     | (32'h0000_0001 << SLOT_RIT)
                                     | (32'h0000_0001 << SLOT_MC_PWM)
                                     | (32'h0000_0001 << SLOT_QUAD_DEC)
                                     | (32'h0000_0001 << SLOT_SYSCON);

endpackage

// ==== src/mlm_matrix.sv ====
// Multilayer bus matrix with per-master address decode and per-port arbitration.

// How it works
// - Masters on different ports proceed concurrently.
// - Instruction and data buses served concurrently.
// - Each SRAM sits on its own port.
// - AHB peripherals: 2 MB, 128 slots.
// - APB peripherals: 1 MB, 64 slots.
// - Slot taken from bit 14 upward.
// - Remap redirects vector area to local SRAM.
// - Second APB region slot assignments fixed.
// - Bit-band alias window decoded separately.
module mlm_matrix
#(
   parameter int NM = 4,
   parameter int DW = 32
)
(
   input  wire logic                                        clk_sys_i,
   input  wire logic                                        sys_rst_i,
   input  wire logic                                        remap_i,
   input  wire logic [NM-1:0]                               m_req_i,
   input  wire logic [NM-1:0][31:0]                         m_addr_i,
   input  wire logic [NM-1:0]                               m_write_i,
   input  wire logic [NM-1:0][DW-1:0]                       m_wdata_i,
   output logic      [NM-1:0]                               m_ack_o,
   output logic      [NM-1:0]                               m_err_o,
   output logic      [NM-1:0][DW-1:0]                       m_rdata_o,
   output logic      [mlm_pkg::NUM_PORTS-1:0]               s_req_o,
   output logic      [mlm_pkg::NUM_PORTS-1:0][31:0]         s_addr_o,
   output logic      [mlm_pkg::NUM_PORTS-1:0]               s_write_o,
   output logic      [mlm_pkg::NUM_PORTS-1:0][DW-1:0]       s_wdata_o,
   output logic      [mlm_pkg::NUM_PORTS-1:0][mlm_pkg::SLOT_W-1:0] s_slot_o,
   input  wire logic [mlm_pkg::NUM_PORTS-1:0]               s_ack_i,
   input  wire logic [mlm_pkg::NUM_PORTS-1:0]               s_err_i,
   input  wire logic [mlm_pkg::NUM_PORTS-1:0][DW-1:0]       s_rdata_i
);

   localparam int NS = mlm_pkg::NUM_PORTS;
   localparam int MW = (NM > 1) ? $clog2(NM) : 1;

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   // Result is {error, port}.
   function automatic logic [4:0] decode_addr(input logic [31:0] a);
      logic [4:0] r;
      r = {1'b1, mlm_pkg::PORT_CODE};
      if (a < mlm_pkg::FLASH_END || (a >= mlm_pkg::ROM_BASE && a < mlm_pkg::ROM_END))
      begin
         r = {1'b0, mlm_pkg::PORT_CODE};
      end
      else if (a >= mlm_pkg::LSRAM_BASE && a < mlm_pkg::LSRAM_END)
      begin
         r = {1'b0, mlm_pkg::PORT_LSRAM};
      end
      else if (a >= mlm_pkg::SRAM0_BASE && a < mlm_pkg::SRAM1_BASE)
      begin
         r = {1'b0, mlm_pkg::PORT_SRAM0};
      end
      else if (a >= mlm_pkg::SRAM1_BASE && a < mlm_pkg::SRAM1_END)
      begin
         r = {1'b0, mlm_pkg::PORT_SRAM1};
      end
      else if (a >= mlm_pkg::APB0_BASE && a < mlm_pkg::APB1_BASE)
      begin
         r = {1'b0, mlm_pkg::PORT_APB0};
      end
      else if (a >= mlm_pkg::APB1_BASE && a < mlm_pkg::APB_END)
      begin
         r = {~mlm_pkg::APB1_USED[a[18:14]], mlm_pkg::PORT_APB1};
      end
      else if (a >= mlm_pkg::BB_BASE && a < mlm_pkg::BB_END)
      begin
         r = {1'b0, mlm_pkg::PORT_BITBAND};
      end
      else if (a >= mlm_pkg::AHBP_BASE && a < mlm_pkg::AHBP_END)
      begin
         r = {1'b0, mlm_pkg::PORT_AHBP};
      end
      else if (a >= mlm_pkg::PPB_BASE && a < mlm_pkg::PPB_END)
      begin
         r = {1'b0, mlm_pkg::PORT_PPB};
      end
      return r;
   endfunction

   logic [NM-1:0][31:0] eff_addr;
   logic [NM-1:0]       dec_err;
   logic [NM-1:0][3:0]  dec_port;

   always_comb
   begin
      for (int m = 0; m < NM; m++)
      begin
         // The vector table moves to local SRAM so software can patch it at run time.
         if (remap_i && m_addr_i[m] < mlm_pkg::VECT_END)
         begin
            eff_addr[m] = mlm_pkg::LSRAM_BASE | m_addr_i[m];
         end
         else
         begin
            eff_addr[m] = m_addr_i[m];
         end
         {dec_err[m], dec_port[m]} = decode_addr(eff_addr[m]);
      end
   end

   // ----------------------------------------------------------------------
   // Arbitration and transfer tracking
   // ----------------------------------------------------------------------
   logic [NM-1:0]                   m_busy_q, m_busy_d;
   logic [NM-1:0]                   m_ack_q, m_ack_d;
   logic [NM-1:0]                   m_err_q, m_err_d;
   logic [NM-1:0][DW-1:0]           m_rdata_q, m_rdata_d;
   logic [NS-1:0]                   s_req_q, s_req_d;
   logic [NS-1:0][31:0]             s_addr_q, s_addr_d;
   logic [NS-1:0]                   s_write_q, s_write_d;
   logic [NS-1:0][DW-1:0]           s_wdata_q, s_wdata_d;
   logic [NS-1:0][mlm_pkg::SLOT_W-1:0] s_slot_q, s_slot_d;
   logic [NS-1:0][MW-1:0]           s_owner_q, s_owner_d;
   logic [NM-1:0]                   grantable;

   always_comb
   begin
      logic found;
      found     = 1'b0;
      m_busy_d  = m_busy_q;
      m_ack_d   = '0;
      m_err_d   = '0;
      m_rdata_d = m_rdata_q;
      s_req_d   = s_req_q;
      s_addr_d  = s_addr_q;
      s_write_d = s_write_q;
      s_wdata_d = s_wdata_q;
      s_slot_d  = s_slot_q;
      s_owner_d = s_owner_q;
      // A request still held in its acknowledge cycle is the old one and must not be taken again.
      grantable = m_req_i & ~m_busy_q & ~m_ack_q;

      for (int s = 0; s < NS; s++)
      begin
         if (s_req_q[s] && s_ack_i[s])
         begin
            s_req_d[s]                = 1'b0;
            m_ack_d[s_owner_q[s]]     = 1'b1;
            m_err_d[s_owner_q[s]]     = s_err_i[s];
            m_rdata_d[s_owner_q[s]]   = s_rdata_i[s];
            m_busy_d[s_owner_q[s]]    = 1'b0;
         end
      end

      for (int m = 0; m < NM; m++)
      begin
         if (grantable[m] && dec_err[m])
         begin
            m_ack_d[m]   = 1'b1;
            m_err_d[m]   = 1'b1;
            m_rdata_d[m] = '0;
         end
      end

      // Each port arbitrates on its own, so masters aimed at different ports win in the same cycle.
      // Fixed priority: the lowest master index wins; a busy port is never preempted.
      for (int s = 0; s < NS; s++)
      begin
         found = 1'b0;
         if (!s_req_q[s])
         begin
            for (int m = 0; m < NM; m++)
            begin
               if (!found && grantable[m] && !dec_err[m] && dec_port[m] == 4'(s))
               begin
                  found        = 1'b1;
                  s_req_d[s]   = 1'b1;
                  s_addr_d[s]  = eff_addr[m];
                  s_write_d[s] = m_write_i[m];
                  s_wdata_d[s] = m_wdata_i[m];
                  s_owner_d[s] = MW'(m);
                  m_busy_d[m]  = 1'b1;
                  if (4'(s) == mlm_pkg::PORT_AHBP)
                  begin
                     s_slot_d[s] = eff_addr[m][mlm_pkg::SLOT_LSB +: 7];
                  end
                  else if (4'(s) == mlm_pkg::PORT_APB0 || 4'(s) == mlm_pkg::PORT_APB1)
                  begin
                     s_slot_d[s] = {2'b00, eff_addr[m][mlm_pkg::SLOT_LSB +: 5]};
                  end
                  else
                  begin
                     s_slot_d[s] = '0;
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         m_busy_q  <= '0;
         m_ack_q   <= '0;
         m_err_q   <= '0;
         m_rdata_q <= '0;
         s_req_q   <= '0;
         s_addr_q  <= '0;
         s_write_q <= '0;
         s_wdata_q <= '0;
         s_slot_q  <= '0;
         s_owner_q <= '0;
      end
      else
      begin
         m_busy_q  <= m_busy_d;
         m_ack_q   <= m_ack_d;
         m_err_q   <= m_err_d;
         m_rdata_q <= m_rdata_d;
         s_req_q   <= s_req_d;
         s_addr_q  <= s_addr_d;
         s_write_q <= s_write_d;
         s_wdata_q <= s_wdata_d;
         s_slot_q  <= s_slot_d;
         s_owner_q <= s_owner_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign m_ack_o   = m_ack_q;
   assign m_err_o   = m_err_q;
   assign m_rdata_o = m_rdata_q;
   assign s_req_o   = s_req_q;
   assign s_addr_o  = s_addr_q;
   assign s_write_o = s_write_q;
   assign s_wdata_o = s_wdata_q;
   assign s_slot_o  = s_slot_q;

endmodule

// ==== sim/mlm_matrix_asserts.sv ====
// Port-level assertions for the multilayer matrix.
module mlm_matrix_asserts
#(
   parameter int NM = 4,
   parameter int DW = 32
)
(
   input wire logic                  clk_sys_i,
   input wire logic                  sys_rst_i,
   input wire logic                  remap_i,
   input wire logic [NM-1:0]         m_req_i,
   input wire logic [NM-1:0][31:0]   m_addr_i,
   input wire logic [NM-1:0]         m_write_i,
   input wire logic [NM-1:0][DW-1:0] m_wdata_i,
   input wire logic [NM-1:0]         m_ack_o,
   input wire logic [NM-1:0]         m_err_o,
   input wire logic [NM-1:0][DW-1:0] m_rdata_o,
   input wire logic [8:0]            s_req_o,
   input wire logic [8:0][31:0]      s_addr_o,
   input wire logic [8:0]            s_write_o,
   input wire logic [8:0][DW-1:0]    s_wdata_o,
   input wire logic [8:0][6:0]       s_slot_o,
   input wire logic [8:0]            s_ack_i,
   input wire logic [8:0]            s_err_i,
   input wire logic [8:0][DW-1:0]    s_rdata_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   err_with_ack_a: assert property ((m_err_o & ~m_ack_o) == '0)
      else $error("error flag without ack");
   ack_pulse_a: assert property (m_ack_o != '0 |=> (m_ack_o & $past(m_ack_o)) == '0)
      else $error("ack longer than one cycle");
   for (genvar p = 0; p < 9; p++)
   begin : g_port
      req_hold_a: assert property (s_req_o[p] && !s_ack_i[p] |=> s_req_o[p] && $stable(s_addr_o[p]))
         else $error("port request not held");
      done_ack_a: assert property (s_req_o[p] && s_ack_i[p] |=> !s_req_o[p] && m_ack_o != '0)
         else $error("slave answer not passed back");
   end
   lsram_win_a: assert property (s_req_o[1] |-> s_addr_o[1][31:15] == 17'h02000)
      else $error("local ram port outside window");
   apb0_slot_a: assert property
      (s_req_o[4] |-> s_addr_o[4][31:19] == 13'h0800 && s_slot_o[4] == {2'h0, s_addr_o[4][18:14]})
      else $error("first apb slot wrong");
   apb1_slot_a: assert property
      (s_req_o[5] |-> s_slot_o[5] == {2'h0, s_addr_o[5][18:14]} && mlm_pkg::APB1_USED[s_addr_o[5][18:14]])
      else $error("second apb slot wrong");
   bitband_win_a: assert property (s_req_o[6] |-> s_addr_o[6][31:25] == 7'h21)
      else $error("alias port outside window");
   ahbp_slot_a: assert property
      (s_req_o[7] |-> s_addr_o[7][31:21] == 11'h280 && s_slot_o[7] == s_addr_o[7][20:14])
      else $error("ahb peripheral slot wrong");
   ppb_win_a: assert property (s_req_o[8] |-> s_addr_o[8][31:20] == 12'hE00)
      else $error("private bus port outside window");
endmodule

// ==== sim/mlm_slave_model.sv ====
// Far-side slave model answering every port of the matrix.
module mlm_slave_model
(
   input  wire logic             clk_sys_i,
   input  wire logic             sys_rst_i,
   input  wire logic             slow_i,
   input  wire logic [8:0]       err_i,
   input  wire logic [8:0]       req_i,
   input  wire logic [8:0][31:0] addr_i,
   output logic      [8:0]       ack_o,
   output logic      [8:0]       err_o,
   output logic      [8:0][31:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0][1:0] cnt_q;
   logic [8:0][1:0] cnt_d;
   logic [8:0]      ack_d;
   logic            tog_q;
   // ----------------------------------------------------------------
   // Wait counters and answers
   // ----------------------------------------------------------------
   // Outside an answer the lines toggle, so a stale value is never taken for data.
   always_comb
   begin
      for (int p = 0; p < 9; p++)
      begin
         cnt_d[p] = (req_i[p] && !ack_o[p]) ? cnt_q[p] + {1'b0, cnt_q[p] != 2'h3} : 2'h0;
         ack_d[p] = req_i[p] && !ack_o[p] && (!slow_i || cnt_q[p] == 2'h3);
         rdata_o[p] = ack_o[p] ? addr_i[p] ^ 32'hA5A5_A5A5 : {16{tog_q, ~tog_q}};
         err_o[p] = ack_o[p] ? err_i[p] : tog_q;
      end
   end
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         cnt_q <= '0;
         ack_o <= '0;
         tog_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         ack_o <= ack_d;
         tog_q <= ~tog_q;
      end
   end
endmodule

// ==== sim/mlm_matrix_bench.sv ====
// Self-checking bench for the multilayer matrix.
bind mlm_matrix mlm_matrix_asserts #(.NM(NM), .DW(DW)) u_chk (.clk_sys_i, .sys_rst_i, .remap_i, .m_req_i,
   .m_addr_i, .m_write_i, .m_wdata_i, .m_ack_o, .m_err_o, .m_rdata_o, .s_req_o, .s_addr_o, .s_write_o,
   .s_wdata_o, .s_slot_o, .s_ack_i, .s_err_i, .s_rdata_i);
module mlm_matrix_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic             clk_sys_i, sys_rst_i, remap_i, slow;
   logic [3:0]       m_req_i, m_write_i, m_ack_o, m_err_o;
   logic [3:0][31:0] m_addr_i, m_wdata_i, m_rdata_o;
   logic [8:0]       s_req_o, s_write_o, s_ack_i, s_err_i, err_sel;
   logic [8:0][31:0] s_addr_o, s_wdata_o, s_rdata_i;
   logic [8:0][6:0]  s_slot_o;
   int               n_errors, n_checks;
   time              t_ack [4];

   mlm_matrix i_dut (.clk_sys_i, .sys_rst_i, .remap_i, .m_req_i, .m_addr_i, .m_write_i, .m_wdata_i,
      .m_ack_o, .m_err_o, .m_rdata_o, .s_req_o, .s_addr_o, .s_write_o, .s_wdata_o, .s_slot_o,
      .s_ack_i, .s_err_i, .s_rdata_i);
   mlm_slave_model i_slv (.clk_sys_i, .sys_rst_i, .slow_i(slow), .err_i(err_sel), .req_i(s_req_o),
      .addr_i(s_addr_o), .ack_o(s_ack_i), .err_o(s_err_i), .rdata_o(s_rdata_i));

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // The request is held until the edge after ack is seen, as the master contract asks.
   task automatic xfer(input int m, input logic [31:0] a, input logic [31:0] ea, input logic e, input logic wr);
      int k;
      logic hit;
      @(posedge clk_sys_i);
      m_req_i[m] <= 1'b1;
      m_addr_i[m] <= a;
      m_write_i[m] <= wr;
      m_wdata_i[m] <= ~a;
      k = 0;
      do
      begin
         @(negedge clk_sys_i);
         k++;
      end
      while (m_ack_o[m] !== 1'b1 && k < 40);
      t_ack[m] = $time;
      check({30'h0, m_ack_o[m], m_err_o[m]}, {30'h0, 1'b1, e});
      if (!e && !wr)
         check(m_rdata_o[m], ea ^ 32'hA5A5_A5A5);
      if (e && err_sel == '0)
         check(m_rdata_o[m], 32'h0);
      // The routed port keeps what it was handed until its next grant, so it is judged in the ack cycle.
      if (!e)
      begin
         hit = 1'b0;
         for (int p = 0; p < 9; p++)
         begin
            if (s_addr_o[p] === ea)
            begin
               hit = 1'b1;
               check({31'h0, s_write_o[p]}, {31'h0, wr});
               check(s_wdata_o[p], ~a);
            end
         end
         check({31'h0, hit}, 32'h1);
      end
      @(posedge clk_sys_i);
      m_req_i[m] <= 1'b0;
   endtask

   task automatic t_map();
      logic [31:0] good [15] = '{32'h400, 32'h1000_0100, 32'h2007_C000, 32'h2008_3FFC, 32'h4000_0000,
         32'h400A_0000, 32'h400A_8000, 32'h400B_0000, 32'h400B_8000, 32'h400B_C000, 32'h400F_C000,
         32'h4200_0000, 32'h43FF_FFFC, 32'h501F_C000, 32'hE00F_FFFC};
      logic [31:0] bad [8] = '{32'h400C_0000, 32'h400F_8000, 32'h400A_C000, 32'h400B_4000, 32'h4010_0000,
         32'h4400_0000, 32'h5020_0000, 32'hE010_0000};
      foreach (good[i])
         xfer(1, good[i], good[i], 1'b0, i[0]);
      foreach (bad[i])
         xfer(0, bad[i], 32'h0, 1'b1, 1'b0);
   endtask

   task automatic t_remap();
      remap_i <= 1'b1;
      slow <= 1'b1;
      xfer(0, 32'h4, 32'h1000_0004, 1'b0, 1'b0);
      remap_i <= 1'b0;
      xfer(0, 32'h4, 32'h4, 1'b0, 1'b0);
      slow <= 1'b0;
   endtask

   task automatic t_conc();
      fork
         xfer(0, 32'h100, 32'h100, 1'b0, 1'b0);
         xfer(1, 32'h1000_0040, 32'h1000_0040, 1'b0, 1'b0);
      join
      check(32'(t_ack[0]), 32'(t_ack[1]));
      fork
         xfer(2, 32'h2007_C010, 32'h2007_C010, 1'b0, 1'b0);
         xfer(3, 32'h2008_0010, 32'h2008_0010, 1'b0, 1'b0);
      join
      check(32'(t_ack[2]), 32'(t_ack[3]));
      fork
         xfer(2, 32'h2007_C020, 32'h2007_C020, 1'b0, 1'b0);
         xfer(3, 32'h2007_C030, 32'h2007_C030, 1'b0, 1'b0);
      join
      check({31'h0, t_ack[3] > t_ack[2]}, 32'h1);
   endtask

   task automatic summarize();
      if (n_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   initial
   begin
      #100us;
      n_errors++;
      summarize();
   end

   initial
   begin
      {sys_rst_i, remap_i, slow, err_sel, m_req_i, m_write_i, m_addr_i, m_wdata_i} = '0;
      sys_rst_i = 1'b1;
      n_errors = 0;
      n_checks = 0;
      repeat (3) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      t_map();
      t_remap();
      t_conc();
      err_sel <= 9'h004;
      xfer(2, 32'h2007_C000, 32'h0, 1'b1, 1'b0);
      err_sel <= 9'h000;
      summarize();
   end
endmodule
